/* verilog/lamp_drive_pkg.sv */
// Constants for the dual-channel lamp drive control block.
// Assumes a 25 MHz APB clock; all registers are one aligned 32-bit word.
package lamp_drive_pkg;

  // --------------------------------------------------------------
  // Register map (byte addresses)
  // --------------------------------------------------------------
  localparam logic [7:0] ADDR_EMI_CONTROL   = 8'h00;
  localparam logic [7:0] ADDR_OVERDRIVE_CFG = 8'h04;
  localparam logic [7:0] ADDR_CONTROL_TWO   = 8'h08;
  localparam logic [7:0] ADDR_LAMP_PERIOD   = 8'h0C;
  localparam logic [7:0] ADDR_STATUS        = 8'h10;

  // --------------------------------------------------------------
  // Field positions
  // --------------------------------------------------------------
  // emi_control_reg: [1:0] step amount (1..4 %), [2] up, [3] enable
  localparam int EMI_AMT_LSB      = 0;
  localparam int EMI_UP_BIT       = 2;
  localparam int EMI_EN_BIT       = 3;
  // overdrive_config_reg: [3:0] overdrive amount, [4] enable
  localparam int OVD_AMT_LSB      = 0;
  localparam int OVD_EN_BIT       = 4;
  // control_reg_two: [0] power-down enable
  localparam int PDN_EN_BIT       = 0;

  // --------------------------------------------------------------
  // Reset values
  // --------------------------------------------------------------
  localparam logic [3:0]  EMI_RESET       = 4'h0;
  localparam logic [4:0]  OVD_RESET       = 5'h00;
  localparam logic [0:0]  CTL2_RESET      = 1'h0;
  localparam logic [11:0] PERIOD_RESET    = 12'h1F4;

  // --------------------------------------------------------------
  // Timing
  // --------------------------------------------------------------
  localparam int CLK_HZ          = 25_000_000;
  localparam int DIM_CLK_MIN_MHZ = 22_500;   // 22.5 Hz in mHz
  localparam int DIM_CLK_MAX_HZ  = 440;
  // Shortest dimming clock period in pclk cycles, rounded down
  localparam int DIM_MIN_CYCLES  = CLK_HZ / DIM_CLK_MAX_HZ;
  // Strike restart pulse length in cycles
  localparam int STRIKE_CYCLES   = 4;
  // Dead time between gate halves in cycles
  localparam int DEAD_CYCLES     = 2;

  typedef enum logic [1:0] {
    CH_OFF    = 2'b00,
    CH_STRIKE = 2'b01,
    CH_RUN    = 2'b10
  } ch_state_e;

endpackage

/* verilog/lamp_drive_control.sv */
// Lamp drive control for two channels: pin and register controls,
// dimming clock burst source and push-pull gate generation.
// Assumes pins synchronous to pclk and an APB master on the bus.
//
// Local design decisions: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps

// What this block does
// - Shift input moves lamp frequency up or down by 1 to 4 percent.
// - Shift applies when shift pin or register enable bit is high.
// - Overdrive pin high raises lamp current by set amount; low with the enable bit clear is nominal.
// - Overdrive applies when overdrive pin or its enable bit is high.
// - Lamp off high stops drive, clears faults, enters power-down.
// - Falling edge of lamp off resets faults and starts a new strike.
// - Lamp off pin ORed with power-down enable bit.
// - External dimming clock 22.5 to 440 Hz times the burst signal.
// - Each channel drives its two gates alternately per half cycle.
// - Gate on-time follows per-channel current sense against reference.
module lamp_drive_control #(
  parameter int PERIOD_W = 12,
  parameter int SENSE_W  = 8
) (
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [7:0]          paddr,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire logic                freq_shift_input,
  input  wire logic                overdrive_input,
  input  wire logic                lamp_off_input,
  input  wire logic                dimming_osc_pin,
  input  wire logic [1:0][SENSE_W-1:0] lamp_current_sense,
  input  wire logic [SENSE_W-1:0]  sense_reference,
  input  wire logic [6:0]          burst_duty,
  output logic      [1:0]          gate_a,
  output logic      [1:0]          gate_b,
  output logic                     burst_dim_signal,
  output logic                     fault_clear,
  output logic                     powered_down,
  output logic      [PERIOD_W-1:0] lamp_period
);

  if (PERIOD_W < 8 || PERIOD_W > 16 || SENSE_W < 2) begin : g_bad_params
    $error("lamp_drive_control: unsupported parameter values");
  end

  // ----------------------------------------------------------------
  // APB registers
  // ----------------------------------------------------------------
  logic [3:0]          emi_q,  emi_d;
  logic [4:0]          ovd_q,  ovd_d;
  logic [0:0]          ctl2_q, ctl2_d;
  logic [PERIOD_W-1:0] per_q,  per_d;
  logic                wr_en, rd_hit;
  logic [31:0]         rdata;

  assign wr_en   = psel && penable && pwrite;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !rd_hit;

  always_comb begin
    emi_d  = emi_q;
    ovd_d  = ovd_q;
    ctl2_d = ctl2_q;
    per_d  = per_q;
    if (wr_en) begin
      case (paddr)
        lamp_drive_pkg::ADDR_EMI_CONTROL:   emi_d  = pwdata[3:0];
        lamp_drive_pkg::ADDR_OVERDRIVE_CFG: ovd_d  = pwdata[4:0];
        lamp_drive_pkg::ADDR_CONTROL_TWO:   ctl2_d = pwdata[0:0];
        lamp_drive_pkg::ADDR_LAMP_PERIOD:   per_d  = pwdata[PERIOD_W-1:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      emi_q  <= lamp_drive_pkg::EMI_RESET;
      ovd_q  <= lamp_drive_pkg::OVD_RESET;
      ctl2_q <= lamp_drive_pkg::CTL2_RESET;
      per_q  <= PERIOD_W'(lamp_drive_pkg::PERIOD_RESET);
    end else begin
      emi_q  <= emi_d;
      ovd_q  <= ovd_d;
      ctl2_q <= ctl2_d;
      per_q  <= per_d;
    end
  end

  // ----------------------------------------------------------------
  // Control combination
  // ----------------------------------------------------------------
  logic       shift_on, ovd_on, off_req;
  logic [1:0] step_amt;
  logic       step_up;
  logic [1:0][1:0] ch_state;

  assign shift_on = freq_shift_input
                    || emi_q[lamp_drive_pkg::EMI_EN_BIT];
  assign ovd_on   = overdrive_input
                    || ovd_q[lamp_drive_pkg::OVD_EN_BIT];
  assign off_req  = lamp_off_input
                    || ctl2_q[lamp_drive_pkg::PDN_EN_BIT];
  assign step_amt = emi_q[lamp_drive_pkg::EMI_AMT_LSB +: 2];
  assign step_up  = emi_q[lamp_drive_pkg::EMI_UP_BIT];

  // Period scaled by (1 +/- n%); step up in frequency shortens period.
  logic [PERIOD_W+7:0] delta_wide;
  logic [PERIOD_W-1:0] delta, eff_period, period_q;
  always_comb begin
    delta_wide = ({8'h00, per_q} * (PERIOD_W+8)'({2'b00, step_amt} + 4'h1))
                 / (PERIOD_W+8)'(100);
    delta      = delta_wide[PERIOD_W-1:0];
    if (!shift_on) begin
      eff_period = per_q;
    end else if (step_up) begin
      eff_period = per_q - delta;
    end else begin
      eff_period = per_q + delta;
    end
  end
  assign lamp_period = period_q;

  // ----------------------------------------------------------------
  // Power-down and strike restart
  // ----------------------------------------------------------------
  logic       off_q;
  logic [2:0] strike_q, strike_d;
  logic       restart;

  assign restart = off_q && !off_req;

  always_comb begin
    strike_d = strike_q;
    if (restart) begin
      strike_d = 3'(lamp_drive_pkg::STRIKE_CYCLES);
    end else if (strike_q != 3'h0) begin
      strike_d = strike_q - 3'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      off_q    <= 1'b0;
      strike_q <= 3'h0;
      period_q <= PERIOD_W'(lamp_drive_pkg::PERIOD_RESET);
    end else begin
      off_q    <= off_req;
      strike_q <= strike_d;
      period_q <= eff_period;
    end
  end

  assign powered_down = off_req;
  assign fault_clear  = off_req || restart;

  // ----------------------------------------------------------------
  // Burst signal timed by the dimming clock
  // ----------------------------------------------------------------
  // Edges come from a pin synchronous to pclk; 128 dimming clock rises make
  // one burst period, duty set by burst_duty (127 is always on).
  logic       dim_q, dim_rise;
  logic [6:0] bcnt_q, bcnt_d;
  logic       burst_q, burst_d;

  assign dim_rise = dimming_osc_pin && !dim_q;

  always_comb begin
    bcnt_d  = bcnt_q;
    if (dim_rise) begin
      bcnt_d = bcnt_q + 7'h01;
    end
    burst_d = (burst_duty == 7'h7F) || (bcnt_q < burst_duty);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dim_q   <= 1'b0;
      bcnt_q  <= 7'h00;
      burst_q <= 1'b0;
    end else begin
      dim_q   <= dimming_osc_pin;
      bcnt_q  <= bcnt_d;
      burst_q <= burst_d;
    end
  end
  assign burst_dim_signal = burst_q;

  // ----------------------------------------------------------------
  // Per-channel push-pull gate drive
  // ----------------------------------------------------------------
  // Overdrive raises the reference so regulation asks for more current;
  // it saturates, since a wrapped sum would cut the current instead.
  logic [SENSE_W-1:0] ref_eff;
  assign ref_eff = !ovd_on ? sense_reference
                 : (sense_reference > ~SENSE_W'(ovd_q[3:0])) ? '1
                 : sense_reference + SENSE_W'(ovd_q[3:0]);

  for (genvar c = 0; c < 2; c++) begin : g_ch
    logic [PERIOD_W-1:0] cnt_q, cnt_d, on_q, on_d;
    logic                half_q, half_d;
    logic                ga_q, ga_d, gb_q, gb_d;
    lamp_drive_pkg::ch_state_e st_q, st_d;
    logic [PERIOD_W-1:0] half_len;
    logic                run;

    assign half_len = eff_period >> 1;
    assign run = !off_req && burst_q && (strike_q == 3'h0);

    always_comb begin
      cnt_d  = cnt_q;
      half_d = half_q;
      on_d   = on_q;
      st_d   = run ? lamp_drive_pkg::CH_RUN : lamp_drive_pkg::CH_OFF;
      if (!run) begin
        cnt_d  = '0;
        half_d = 1'b0;
      end else if (cnt_q >= half_len - PERIOD_W'(1)) begin
        cnt_d  = '0;
        half_d = !half_q;
        // Regulate once per half cycle
        if (lamp_current_sense[c] < ref_eff) begin
          if (on_q < half_len - PERIOD_W'(lamp_drive_pkg::DEAD_CYCLES)) begin
            on_d = on_q + PERIOD_W'(1);
          end
        end else if (on_q != '0) begin
          on_d = on_q - PERIOD_W'(1);
        end
      end else begin
        cnt_d = cnt_q + PERIOD_W'(1);
      end
      ga_d = run && !half_q && (cnt_q < on_q);
      gb_d = run &&  half_q && (cnt_q < on_q);
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        cnt_q  <= '0;
        half_q <= 1'b0;
        on_q   <= '0;
        ga_q   <= 1'b0;
        gb_q   <= 1'b0;
        st_q   <= lamp_drive_pkg::CH_OFF;
      end else begin
        cnt_q  <= cnt_d;
        half_q <= half_d;
        on_q   <= on_d;
        ga_q   <= ga_d;
        gb_q   <= gb_d;
        st_q   <= st_d;
      end
    end
    assign gate_a[c] = ga_q;
    assign gate_b[c] = gb_q;
    assign ch_state[c] = st_q;

    a_gates_exclusive: assert property (
      @(posedge pclk) disable iff (!presetn) !(ga_q && gb_q))
      else $error("both gates of a channel high");
    a_gate_off_idle: assert property (
      @(posedge pclk) disable iff (!presetn)
      $past(off_req) |-> !ga_q && !gb_q)
      else $error("gate high after power-down");
  end

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  always_comb begin
    rd_hit = 1'b1;
    rdata  = 32'h0000_0000;
    case (paddr)
      lamp_drive_pkg::ADDR_EMI_CONTROL:   rdata[3:0] = emi_q;
      lamp_drive_pkg::ADDR_OVERDRIVE_CFG: rdata[4:0] = ovd_q;
      lamp_drive_pkg::ADDR_CONTROL_TWO:   rdata[0]   = ctl2_q[0];
      lamp_drive_pkg::ADDR_LAMP_PERIOD:   rdata[PERIOD_W-1:0] = eff_period;
      lamp_drive_pkg::ADDR_STATUS: begin
        rdata[0] = off_req;
        rdata[1] = shift_on;
        rdata[2] = ovd_on;
        rdata[3] = burst_q;
        rdata[5:4] = ch_state[0];
        rdata[7:6] = ch_state[1];
      end
      default: rd_hit = 1'b0;
    endcase
  end
  assign prdata = (psel && !pwrite) ? rdata : 32'h0000_0000;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_off_release;
    off_req ##1 !off_req;
  endsequence

  a_restart_strike: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_off_release |-> fault_clear ##1 (strike_q == 3'h4))
    else $error("no strike restart on lamp-off release");
  a_off_clears: assert property (
    @(posedge pclk) disable iff (!presetn)
    off_req |-> fault_clear && powered_down)
    else $error("fault logic not held clear while off");
  a_pdn_bit_or: assert property (
    @(posedge pclk) disable iff (!presetn)
    ctl2_q[0] |-> powered_down)
    else $error("power-down bit ignored");
  a_shift_period: assert property (
    @(posedge pclk) disable iff (!presetn)
    (shift_on && step_up) |-> eff_period < per_q || delta == '0)
    else $error("upward shift did not shorten period");
  a_shift_or: assert property (
    @(posedge pclk) disable iff (!presetn)
    !freq_shift_input && !emi_q[3] |-> eff_period == per_q)
    else $error("shift applied without a source");
  a_ovd_or: assert property (
    @(posedge pclk) disable iff (!presetn)
    overdrive_input |-> ovd_on)
    else $error("overdrive pin ignored");
  a_ovd_nominal: assert property (
    @(posedge pclk) disable iff (!presetn)
    !ovd_on |-> ref_eff == sense_reference)
    else $error("current not nominal without overdrive");
  a_burst_gap: assert property (
    @(posedge pclk) disable iff (!presetn)
    !burst_q |=> gate_a == 2'b00 && gate_b == 2'b00)
    else $error("gate high between bursts");
  a_dim_count: assert property (
    @(posedge pclk) disable iff (!presetn)
    dim_rise |=> bcnt_q == $past(bcnt_q) + 7'h01)
    else $error("dimming clock edge not counted");

endmodule

/* verification/lamp_switch_model.sv */
// Push-pull switch pair and transformer model, one pair per channel.
// Assumes gates registered on pclk; sense is a crude lamp current level.
`timescale 1ns/1ps
module lamp_switch_model (
  input  wire logic            pclk,
  input  wire logic            presetn,
  input  wire logic [1:0]      gate_a,
  input  wire logic [1:0]      gate_b,
  output logic      [1:0][7:0] lamp_current_sense,
  output logic                 shoot_through
);
  // ----------------------------------------------------------------
  // Current build-up
  // ----------------------------------------------------------------
  logic [1:0][7:0] sense_q;

  // Both switches on shorts the primary: flagged, never drives current
  assign shoot_through      = |(gate_a & gate_b);
  assign lamp_current_sense = sense_q;

  // Current rises while one switch conducts and bleeds off otherwise
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sense_q <= '0;
    end else begin
      for (int c = 0; c < 2; c++) begin
        if ((gate_a[c] ^ gate_b[c]) && sense_q[c] != 8'hFF) begin
          sense_q[c] <= sense_q[c] + 8'h01;
        end else if (!(gate_a[c] ^ gate_b[c]) && sense_q[c] != 8'h00) begin
          sense_q[c] <= sense_q[c] - 8'h01;
        end
      end
    end
  end
endmodule

/* verification/lamp_drive_control_tb.sv */
// Self-checking bench for the lamp drive control block.
// Assumes the switch model on the gates and an APB master in this bench.
`timescale 1ns/1ps
module lamp_drive_control_tb;
  logic             pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]       paddr, sense_reference;
  logic [31:0]      pwdata, prdata, rd;
  logic             freq_shift_input, overdrive_input, lamp_off_input;
  logic             dimming_osc_pin, burst_dim_signal, fault_clear;
  logic             powered_down, shoot_through, er, near;
  int               gap [2];
  logic [1:0][7:0]  lamp_current_sense;
  logic [6:0]       burst_duty;
  logic [1:0]       gate_a, gate_b, pa, pb;
  logic [1:0][1:0]  lst;
  logic [11:0]      lamp_period;
  int               bad_count, compares, on_cnt, w1, n, dim_cnt;

  lamp_drive_control u_dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .freq_shift_input, .overdrive_input,
    .lamp_off_input, .dimming_osc_pin, .lamp_current_sense,
    .sense_reference, .burst_duty, .gate_a, .gate_b, .burst_dim_signal,
    .fault_clear, .powered_down, .lamp_period
  );
  lamp_switch_model u_sw (
    .pclk, .presetn, .gate_a, .gate_b, .lamp_current_sense, .shoot_through
  );

  // ----------------------------------------------------------------
  // Clocks, checks and bus
  // ----------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  // Dimming clock just under 440 Hz: a 28410-cycle half period keeps it
  // inside the allowed band, where 28409 cycles would run a hair above it
  always @(posedge pclk) begin
    if (dim_cnt == lamp_drive_pkg::CLK_HZ
                   / (2 * lamp_drive_pkg::DIM_CLK_MAX_HZ)) begin
      dim_cnt <= 0;
      dimming_osc_pin <= ~dimming_osc_pin;
    end else begin
      dim_cnt <= dim_cnt + 1;
    end
  end

  task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s exp %h got %h", nm, exp, got);
    end
  endtask

  task automatic apb(logic wr, logic [7:0] a, logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Gate pair watch: overlap and alternation, on-time of channel 0.
  // A half with zero on-time legally skips a pulse, so a gate rising
  // twice in a row is only a fault when the two rises are under three quarters of a period apart.
  always @(posedge pclk) begin
    if (presetn === 1'b1) begin
      chk("gate_overlap", 32'h0, {30'h0, gate_a & gate_b});
      chk("shoot_through", 32'h0, {31'h0, shoot_through});
      for (int c = 0; c < 2; c++) begin
        if (powered_down === 1'b1) lst[c] = 2'h0;
        gap[c]++;
        near = gap[c] * 4 < int'(lamp_period) * 3;
        if (gate_a[c] === 1'b1 && pa[c] === 1'b0) begin
          chk("alt_a", 32'h0, {31'h0, lst[c] == 2'h1 && near});
          lst[c] = 2'h1;
          gap[c] = 0;
        end
        if (gate_b[c] === 1'b1 && pb[c] === 1'b0) begin
          chk("alt_b", 32'h0, {31'h0, lst[c] == 2'h2 && near});
          lst[c] = 2'h2;
          gap[c] = 0;
        end
      end
      on_cnt += int'(gate_a[0]) + int'(gate_b[0]);
    end
    pa = gate_a;
    pb = gate_b;
  end

  initial begin
    repeat (60000) @(posedge pclk);
    bad_count++;
    end_sim();
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {freq_shift_input, overdrive_input, lamp_off_input} = '0;
    {dimming_osc_pin, dim_cnt, pa, pb, lst, on_cnt} = '0;
    {bad_count, compares} = '0;
    gap = '{default: 0};
    sense_reference = 8'h80;
    burst_duty = 7'h7F;
    presetn = 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, 8'(i * 4), 32'h0);
      chk("reset_value", (i == 3) ? 32'h1F4 : 32'h0, rd);
    end
    apb(1'b1, 8'h14, 32'hFFFFFFFF);
    chk("unmapped_err", 32'h1, {31'h0, er});
    apb(1'b0, 8'h14, 32'h0);
    chk("unmapped_rd", 32'h0, rd);
    // Every amount, both directions, from the pin and from the bit
    for (int i = 0; i < 16; i++) begin
      apb(1'b1, lamp_drive_pkg::ADDR_EMI_CONTROL, 32'(i % 8 + (i / 8) * 8));
      freq_shift_input <= (i < 8);
      repeat (2) @(posedge pclk);
      #1;
      n = 500 + ((i / 4) % 2 ? -5 : 5) * (i % 4 + 1);
      chk("shift_period", 32'(n), {20'h0, lamp_period});
    end
    freq_shift_input <= 1'b0;
    apb(1'b1, lamp_drive_pkg::ADDR_EMI_CONTROL, 32'h7);
    apb(1'b0, lamp_drive_pkg::ADDR_LAMP_PERIOD, 32'h0);
    chk("shift_off", 32'h1F4, rd);
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, lamp_drive_pkg::ADDR_OVERDRIVE_CFG, (i == 1) ? 32'h15 : 32'h5);
      overdrive_input <= (i == 0);
      apb(1'b0, lamp_drive_pkg::ADDR_STATUS, 32'h0);
      chk("overdrive", (i < 2) ? 32'h1 : 32'h0, {31'h0, rd[2]});
    end
    @(posedge pclk);
    lamp_off_input <= 1'b1;
    repeat (3) @(posedge pclk);
    #1;
    chk("off_state", 32'h3, {30'h0, powered_down, fault_clear});
    chk("off_gates", 32'h0, {30'h0, gate_a | gate_b});
    @(posedge pclk);
    lamp_off_input <= 1'b0;
    #1;
    chk("restart", 32'h1, {30'h0, powered_down, fault_clear});
    @(posedge pclk);
    #1;
    chk("restart_end", 32'h0, {30'h0, powered_down, fault_clear});
    apb(1'b1, lamp_drive_pkg::ADDR_CONTROL_TWO, 32'h1);
    #1;
    chk("off_bit", 32'h1, {31'h0, powered_down});
    apb(1'b1, lamp_drive_pkg::ADDR_CONTROL_TWO, 32'h0);
    n = 0;
    while (burst_dim_signal !== 1'b1 && n < 70000) begin
      @(posedge pclk);
      n++;
    end
    chk("burst_on", 32'h1, {31'h0, burst_dim_signal});
    sense_reference <= 8'h00;
    repeat (3000) @(posedge pclk);
    sense_reference <= 8'hFF;
    on_cnt = 0;
    repeat (2000) @(posedge pclk);
    w1 = on_cnt;
    on_cnt = 0;
    repeat (2000) @(posedge pclk);
    chk("on_time_grows", 32'h1, {31'h0, on_cnt > w1});
    chk("both_gates_seen", 32'h3, {30'h0, lst[0] != 0, lst[1] != 0});
    apb(1'b0, lamp_drive_pkg::ADDR_STATUS, 32'h0);
    chk("run_state", 32'hA, {28'h0, rd[7:4]});
    // A duty of one ends the burst at the first dimming clock rise
    burst_duty <= 7'h01;
    n = 0;
    while (burst_dim_signal !== 1'b0 && n < 40000) begin
      @(posedge pclk);
      n++;
    end
    chk("burst_off", 32'h0, {31'h0, burst_dim_signal});
    chk("burst_edge", 32'h1, {31'h0, dimming_osc_pin});
    repeat (2) @(posedge pclk);
    #1;
    chk("burst_gates", 32'h0, {30'h0, gate_a | gate_b});
    end_sim();
  end
endmodule
